//--- design/rct_regs.vh
`ifndef RCT_REGS_VH
`define RCT_REGS_VH

// register offsets
`define RCT_ADDR_PWR 4'h0
`define RCT_ADDR_CPU 4'h1
`define RCT_ADDR_IRQ 4'h2
`define RCT_ADDR_MSK 4'h3
`define RCT_ADDR_CFG 4'h4
`define RCT_ADDR_PC 4'h5
// field positions
`define RCT_BIT_BOR 0
`define RCT_BIT_POR 1
`define RCT_BIT_PD 3
`define RCT_BIT_TO 4
// reset values and the interrupt vector
`define RCT_RST_CFG 8'h03
`define RCT_RST_VEC 13'h0000
`define RCT_IRQ_VEC 13'h0004
// timing
`define RCT_POWERUP_TIMER_US 72000
`define RCT_CLK_MHZ 250
`define RCT_OST_CYC 1024
// reset and wake causes
`define RCT_EV_POR 3'h0
`define RCT_EV_BOR 3'h1
`define RCT_EV_WDT 3'h2
`define RCT_EV_EXR 3'h3
`define RCT_EV_EXS 3'h4
`define RCT_EV_WWK 3'h5
`define RCT_EV_IWK 3'h6
`endif

//--- design/rct_reset_cause.v
// Added by the designer: the register addresses and the plain strobed port.
`include "rct_regs.vh"

module rct_reset_cause #(
  parameter HAS_BOR = 1,
  parameter POWERUP_TIMER_CYC = `RCT_POWERUP_TIMER_US * `RCT_CLK_MHZ,
  parameter OST_CYC = `RCT_OST_CYC
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_por_pin,
  input wire i_bor_pin,
  input wire i_external_reset_pin_b_pin,
  input wire i_wdt_evt,
  input wire i_sleep,
  input wire i_irq_wake,
  input wire i_gie,
  input wire i_osc_tick,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  output reg o_cpu_reset,
  output reg o_pc_load,
  output reg [12:0] o_pc_val,
  output reg o_pc_next,
  output reg o_irq
);

  localparam ST_RUN = 2'h0;
  localparam ST_POWERUP_TIMER = 2'h1;
  localparam ST_OST = 2'h2;
  localparam ST_HOLD = 2'h3;

  // three-flop pin sync; change counts when flops 2 and 3 agree
  reg [2:0] por_s, bor_s, external_reset_pin_s;
  reg por_f, bor_f, external_reset_pin_f;
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      por_s <= 3'h0;
      bor_s <= 3'h0;
      external_reset_pin_s <= 3'h7;
      por_f <= 1'b0;
      bor_f <= 1'b0;
      external_reset_pin_f <= 1'b1;
    end
    else
    begin
      por_s <= {por_s[1:0], i_por_pin};
      bor_s <= {bor_s[1:0], i_bor_pin};
      external_reset_pin_s <= {external_reset_pin_s[1:0], i_external_reset_pin_b_pin};
      if (por_s[1] == por_s[2]) por_f <= por_s[2];
      if (bor_s[1] == bor_s[2]) bor_f <= bor_s[2];
      if (external_reset_pin_s[1] == external_reset_pin_s[2]) external_reset_pin_f <= external_reset_pin_s[2];
    end
  end

  // one write strobe aimed at one register offset
  function reg_hit;
    input strobe;
    input [3:0] addr;
    input [3:0] target;
    begin
      reg_hit = strobe && (addr == target);
    end
  endfunction

  // shared expiry test for both timers; limit counts whole periods
  function timer_done;
    input [31:0] cnt;
    input [31:0] limit;
    begin
      timer_done = (cnt + 32'h1) >= limit;
    end
  endfunction

  // sequencer state and pending time-outs
  reg external_reset_pin_q;
  reg [1:0] st_q;
  reg [31:0] cnt_q;
  reg ost_pend_q;
  reg powerup_timer_pend_q;
  reg wake_pend_q;
  reg pwr_bor_q, pwr_por_q, to_q, pd_q;
  reg [7:0] cfg_q, sts_q, msk_q;
  reg wake_irq_q;
  // cfg bit0 powerup_timer enable, bit1 brown-out enable, bit2 crystal mode
  wire powerup_timer_enable = cfg_q[0];
  wire brownout_enable_cfg = cfg_q[1] && (HAS_BOR != 0);
  wire xtal = cfg_q[2];
  wire bor_act = bor_f && brownout_enable_cfg;
  wire external_reset_pin_fall = external_reset_pin_q && !external_reset_pin_f;
  // wakes and watchdog only count while the core runs
  wire wdt_run = i_wdt_evt && !i_sleep && st_q == ST_RUN;
  wire wdt_wake = i_wdt_evt && i_sleep && st_q == ST_RUN;
  wire int_wake = i_irq_wake && i_sleep && st_q == ST_RUN;
  // register write decodes
  wire wr_pwr = reg_hit(i_wr, i_addr, `RCT_ADDR_PWR);
  wire wr_cpu = reg_hit(i_wr, i_addr, `RCT_ADDR_CPU);
  wire wr_irq = reg_hit(i_wr, i_addr, `RCT_ADDR_IRQ);
  wire wr_msk = reg_hit(i_wr, i_addr, `RCT_ADDR_MSK);
  wire wr_cfg = reg_hit(i_wr, i_addr, `RCT_ADDR_CFG);
  // a sleeping core is not reset while its oscillator restarts
  wire wake_run = wake_pend_q;
  // wake finished: core resumes at the next instruction
  wire wake_done = wake_pend_q && (st_q == ST_RUN);

  // event bits: 0 por,1 bor,2 wdt,3 ext run,4 ext sleep,5/6 wakes
  reg [7:0] ev;
  always @*
  begin
    ev = 8'h00;
    if (por_f) ev[`RCT_EV_POR] = 1'b1;
    else if (bor_act) ev[`RCT_EV_BOR] = 1'b1;
    else if (external_reset_pin_fall) ev[i_sleep ? `RCT_EV_EXS : `RCT_EV_EXR] = 1'b1;
    else if (wdt_run) ev[`RCT_EV_WDT] = 1'b1;
    else if (wdt_wake) ev[`RCT_EV_WWK] = 1'b1;
    else if (int_wake) ev[`RCT_EV_IWK] = 1'b1;
  end

  // sequencer: hold, power-up timer, oscillator start timer
  // one counter serves both timers; they never overlap
  // async reset counts as a power-on with the timer pending
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      external_reset_pin_q <= 1'b1;
      st_q <= ST_HOLD;
      cnt_q <= 32'h0;
      ost_pend_q <= 1'b0;
      powerup_timer_pend_q <= 1'b1;
      wake_pend_q <= 1'b0;
      wake_irq_q <= 1'b0;
    end
    else
    begin
      external_reset_pin_q <= external_reset_pin_f;
      if (ev[`RCT_EV_POR] || ev[`RCT_EV_BOR])
      begin
        // restart from initial value while supply is bad
        st_q <= ST_HOLD;
        cnt_q <= 32'h0;
        wake_pend_q <= 1'b0;
        // power-on runs the timer only if enabled
        // brown-out always runs it
        powerup_timer_pend_q <= powerup_timer_enable || ev[`RCT_EV_BOR];
        ost_pend_q <= xtal;
      end
      else if (ev[`RCT_EV_WWK] || ev[`RCT_EV_IWK])
      begin
        // wake skips the power-up timer; crystal restarts
        wake_pend_q <= 1'b1;
        wake_irq_q <= ev[`RCT_EV_IWK];
        st_q <= xtal ? ST_OST : ST_RUN;
        cnt_q <= 32'h0;
      end
      else if (ev[`RCT_EV_WDT] || ev[`RCT_EV_EXR] || ev[`RCT_EV_EXS])
      begin
        // no time-outs for these resets
        st_q <= ST_HOLD;
        cnt_q <= 32'h0;
        wake_pend_q <= 1'b0;
        powerup_timer_pend_q <= 1'b0;
        ost_pend_q <= 1'b0;
      end
      else
      begin
        case (st_q)
          ST_RUN:
          begin
            // the wake completion pulse has now been issued
            wake_pend_q <= 1'b0;
          end
          ST_HOLD:
          begin
            // leave once external pin is high and supply is good
            // pending time-outs start only after the pin is released
            if (external_reset_pin_f && !bor_act)
            begin
              cnt_q <= 32'h0;
              if (powerup_timer_pend_q) st_q <= ST_POWERUP_TIMER;
              else if (ost_pend_q) st_q <= ST_OST;
              else st_q <= ST_RUN;
            end
          end
          ST_POWERUP_TIMER:
          begin
            // a new brown-out above restarts this from zero
            if (timer_done(cnt_q, POWERUP_TIMER_CYC))
            begin
              cnt_q <= 32'h0;
              powerup_timer_pend_q <= 1'b0;
              st_q <= ost_pend_q ? ST_OST : ST_RUN;
            end
            else cnt_q <= cnt_q + 32'h1;
          end
          ST_OST:
          begin
            // counts oscillator periods only
            if (i_osc_tick)
            begin
              if (timer_done(cnt_q, OST_CYC))
              begin
                st_q <= ST_RUN;
                ost_pend_q <= 1'b0;
                cnt_q <= 32'h0;
              end
              else cnt_q <= cnt_q + 32'h1;
            end
          end
          default: st_q <= ST_RUN;
        endcase
      end
    end
  end

  // flags, software writes can set them; hardware clear wins
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pwr_bor_q <= 1'b0;
      pwr_por_q <= 1'b0;
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end
    else
    begin
      if (wr_pwr)
      begin
        pwr_por_q <= i_wdata[`RCT_BIT_POR];
        pwr_bor_q <= i_wdata[`RCT_BIT_BOR] && (HAS_BOR != 0);
      end
      if (wr_cpu)
      begin
        to_q <= i_wdata[`RCT_BIT_TO];
        pd_q <= i_wdata[`RCT_BIT_PD];
      end
      if (ev[`RCT_EV_POR])
      begin
        pwr_por_q <= 1'b0;
        to_q <= 1'b1;
        pd_q <= 1'b1;
      end
      if (ev[`RCT_EV_BOR])
      begin
        pwr_bor_q <= 1'b0;
        to_q <= 1'b1;
        pd_q <= 1'b1;
      end
      if (ev[`RCT_EV_WDT])
      begin
        to_q <= 1'b0;
        pd_q <= 1'b1;
      end
      if (ev[`RCT_EV_WWK])
      begin
        to_q <= 1'b0;
        pd_q <= 1'b0;
      end
      if (ev[`RCT_EV_EXS] || ev[`RCT_EV_IWK])
      begin
        to_q <= 1'b1;
        pd_q <= 1'b0;
      end
    end
  end

  // program counter steering and outputs
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_cpu_reset <= 1'b1;
      o_pc_load <= 1'b0;
      o_pc_val <= `RCT_RST_VEC;
      o_pc_next <= 1'b0;
    end
    else
    begin
      // a waking core stays asleep, not in reset, during restart
      o_cpu_reset <= (st_q != ST_RUN) && !wake_run;
      o_pc_load <= 1'b0;
      o_pc_next <= 1'b0;
      if (ev[`RCT_EV_POR] || ev[`RCT_EV_BOR] || ev[`RCT_EV_WDT] ||
          ev[`RCT_EV_EXR] || ev[`RCT_EV_EXS])
      begin
        o_pc_load <= 1'b1;
        o_pc_val <= `RCT_RST_VEC;
      end
      else if (wake_done)
      begin
        o_pc_next <= 1'b1;
        if (wake_irq_q && i_gie)
        begin
          o_pc_load <= 1'b1;
          o_pc_val <= `RCT_IRQ_VEC;
        end
      end
    end
  end

  // sticky interrupt status, write one clears, set wins
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sts_q <= 8'h00;
      msk_q <= 8'h00;
      cfg_q <= `RCT_RST_CFG;
      o_irq <= 1'b0;
      o_rdata <= 8'h00;
    end
    else
    begin
      // set wins over a same-cycle write-one clear
      sts_q <= (sts_q & ~(wr_irq ? i_wdata : 8'h00)) | ev;
      if (wr_msk) msk_q <= i_wdata;
      if (wr_cfg) cfg_q <= i_wdata;
      o_irq <= |(sts_q & msk_q);
      o_rdata <= 8'h00;
      if (i_rd)
      begin
        case (i_addr)
          `RCT_ADDR_PWR: o_rdata <= {6'h00, pwr_por_q, pwr_bor_q};
          `RCT_ADDR_CPU: o_rdata <= {3'h0, to_q, pd_q, 3'h0};
          `RCT_ADDR_IRQ: o_rdata <= sts_q;
          `RCT_ADDR_MSK: o_rdata <= msk_q;
          `RCT_ADDR_CFG: o_rdata <= cfg_q;
          `RCT_ADDR_PC: o_rdata <= {6'h00, st_q};
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

//--- verif/rct_monitor.sv
module rct_monitor #(
  parameter int POWERUP_TIMER_CYC = 20
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_por_pin,
  input wire i_bor_pin,
  input wire i_external_reset_pin_b_pin,
  input wire i_wdt_evt,
  input wire i_sleep,
  input wire [3:0] i_addr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire o_cpu_reset,
  input wire o_pc_load,
  input wire [12:0] o_pc_val
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold_q;
  logic armed_q;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);
  // held cycles since the last detector pulse, armed until release
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      hold_q <= 0;
      armed_q <= 1'b0;
    end
    else if (i_por_pin || i_bor_pin)
    begin
      hold_q <= 0;
      armed_q <= 1'b1;
    end
    else
    begin
      if (o_cpu_reset)
        hold_q <= hold_q + 1;
      if ($fell(o_cpu_reset))
        armed_q <= 1'b0;
    end
  end
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  AST_RD_UNMAP: assert property ($past(i_rd) && $past(i_addr) > 4'h5
    |-> o_rdata == 8'h00) else $error("unmapped read not zero");
  AST_PWR_HI: assert property ($past(i_rd) && $past(i_addr) == 4'h0
    |-> o_rdata[7:2] == 6'h00) else $error("power status high bits set");
  AST_DET_RST: assert property ($rose(i_por_pin) || $rose(i_bor_pin)
    |-> ##[1:8] o_cpu_reset) else $error("no reset after detector");
  AST_POWERUP_TIMER_HOLD: assert property ($fell(o_cpu_reset) && armed_q
    |-> hold_q >= POWERUP_TIMER_CYC - 1) else $error("power-up delay too short");
  AST_EXT_RST: assert property ($fell(i_external_reset_pin_b_pin) && !o_cpu_reset
    |-> ##[1:8] o_cpu_reset) else $error("no reset after pin");
  AST_WDT_RST: assert property (i_wdt_evt && !i_sleep && !o_cpu_reset
    |-> ##[1:8] o_cpu_reset) else $error("no reset after watchdog");
  AST_PC_VEC: assert property (o_pc_load
    |-> o_pc_val inside {13'h0000, 13'h0004}) else $error("bad pc vector");
  cover property (armed_q && $fell(o_cpu_reset));
  cover property (o_pc_load && o_pc_val == 13'h0004);
  cover property (i_wdt_evt && i_sleep);
endmodule

//--- verif/tb_rct_reset_cause.sv
module tb_rct_reset_cause;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk, i_rst_b, i_por_pin, i_bor_pin, i_external_reset_pin_b_pin, i_wdt_evt;
  logic i_sleep, i_irq_wake, i_gie, i_osc_tick, i_wr, i_rd;
  logic o_cpu_reset, o_pc_load, o_pc_next, o_irq;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d;
  logic [12:0] o_pc_val, last_pc;
  int fail_count, cmp_count, cyc, nexts, n;
  int seed = 59389;
  // event table: kind, sleeping, cpu status, pc load
  int kind[6] = '{3, 2, 3, 2, 4, 3};
  int slp[6] = '{0, 0, 0, 1, 1, 1};
  int ecpu[6] = '{'h18, 'h08, 'h08, 'h00, 'h10, 'h10};
  int epc[6] = '{0, 0, 0, 'h1fff, 4, 0};

  rct_reset_cause #(.POWERUP_TIMER_CYC(20)) dut (.i_sys_clk, .i_rst_b, .i_por_pin,
    .i_bor_pin, .i_external_reset_pin_b_pin, .i_wdt_evt, .i_sleep, .i_irq_wake, .i_gie,
    .i_osc_tick, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_cpu_reset,
    .o_pc_load, .o_pc_val, .o_pc_next, .o_irq);

  initial
  begin
    i_sys_clk = 0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  // pc watch, random osc ticks and a hang limit
  always @(posedge i_sys_clk)
  begin
    i_osc_tick <= $random(seed);
    if (o_pc_load === 1'b1)
      last_pc <= o_pc_val;
    if (o_pc_next === 1'b1)
      nexts++;
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input [3:0] a, input [7:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1;
    @(posedge i_sys_clk);
    i_wr <= 0;
  endtask

  task automatic rd(input [3:0] a, input [7:0] m, input [7:0] e);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1;
    @(posedge i_sys_clk);
    i_rd <= 0;
    #1 chk(o_rdata & m, e);
  endtask

  // bounded wait until the sequencer runs again
  task automatic wait_run();
    n = 0;
    while (o_cpu_reset !== 1'b0 && n < 300)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    chk(o_cpu_reset, 0);
  endtask

  // event pulse (one cycle, pins three); power-on needs no running state first
  task automatic ev(input int k);
    if (k != 0)
      wait_run();
    @(posedge i_sys_clk);
    case (k)
      0: i_por_pin <= 1;
      1: i_bor_pin <= 1;
      2: i_wdt_evt <= 1;
      3: i_external_reset_pin_b_pin <= 0;
      default: i_irq_wake <= 1;
    endcase
    @(posedge i_sys_clk);
    {i_wdt_evt, i_irq_wake} <= 2'h0;
    // pins pass a three-flop filter: hold them three cycles
    repeat (2) @(posedge i_sys_clk);
    {i_por_pin, i_bor_pin} <= 2'h0;
    i_external_reset_pin_b_pin <= 1;
    repeat (6) @(posedge i_sys_clk);
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    {i_por_pin, i_bor_pin, i_wdt_evt, i_sleep, i_irq_wake} = 5'h0;
    {i_osc_tick, i_wr, i_rd, i_rst_b, i_addr, i_wdata} = 16'h0;
    {i_external_reset_pin_b_pin, i_gie} = 2'h3;
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1;
    ev(0);
    wait_run();
    rd(0, 8'hfe, 0);
    rd(1, 8'h18, 8'h18);
    wr(2, 8'hff);
    rd(2, 8'hff, 0);
    d = $random(seed);
    wr(0, d);
    rd(0, 8'hff, d & 8'h03);
    rd(4'hf, 8'hff, 0);
    wr(0, 8'h03);
    $display("test power-on done");
    // second brown-out while the power-up delay still runs
    ev(1);
    repeat (4) @(posedge i_sys_clk);
    i_bor_pin <= 1;
    repeat (3) @(posedge i_sys_clk);
    i_bor_pin <= 0;
    repeat (16) @(posedge i_sys_clk);
    chk(o_cpu_reset, 1);
    wait_run();
    rd(0, 8'hff, 8'h02);
    wr(0, 8'h03);
    $display("test brown-out done");
    for (int i = 0; i < 6; i++)
    begin
      i_sleep <= slp[i];
      last_pc = 13'h1fff;
      ev(kind[i]);
      wait_run();
      i_sleep <= 0;
      chk(last_pc, epc[i]);
      rd(1, 8'h18, ecpu[i]);
      rd(0, 8'hff, 8'h03);
      $display("test event %0d done", kind[i]);
    end
    chk(nexts, 2);
    rd(2, 8'hff, 8'h7e);
    chk(o_irq, 0);
    wr(3, 8'h40);
    repeat (3) @(posedge i_sys_clk);
    chk(o_irq, 1);
    wr(2, 8'h40);
    repeat (3) @(posedge i_sys_clk);
    chk(o_irq, 0);
    $display("test interrupt done");
    test_done();
  end
endmodule

bind rct_reset_cause rct_monitor #(.POWERUP_TIMER_CYC(POWERUP_TIMER_CYC)) u_mon (.i_sys_clk,
  .i_rst_b, .i_por_pin, .i_bor_pin, .i_external_reset_pin_b_pin, .i_wdt_evt, .i_sleep,
  .i_addr, .i_rd, .o_rdata, .o_cpu_reset, .o_pc_load, .o_pc_val);
